//--- include/dpmp_pkg.sv
// constants, codes and carrier structs for the loop mode and input pre-divider block
// assumes one 250 MHz system clock and a plain strobe register port
package dpmp_pkg;
  localparam int NUM_IN    = 6;
  localparam int NUM_HF_IN = 4;
  // register map, byte addresses
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_SLOPE   = 8'h04;
  localparam logic [7:0] OFS_FLIMIT  = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_PHASE   = 8'h10;
  localparam logic [7:0] OFS_IN_BASE = 8'h20;
  localparam logic [7:0] IN_STRIDE   = 8'h10;
  localparam logic [7:0] IN_CFG      = 8'h00;
  localparam logic [7:0] IN_INTEGER_DIVIDER_LO  = 8'h04;
  localparam logic [7:0] IN_INTEGER_DIVIDER_HI  = 8'h08;
  localparam logic [7:0] IN_FRAC     = 8'h0C;
  // control field positions
  localparam int CTRL_HS_EN     = 0;
  localparam int CTRL_FREEZE    = 1;
  localparam int CTRL_SLOPE_LSB = 2;
  localparam int CTRL_MODE_LSB  = 5;
  localparam int CTRL_PDN       = 8;
  localparam int CTRL_AVG       = 9;
  localparam int CTRL_SYNC_LSB  = 10;
  localparam logic [11:0] CTRL_RESET = 12'h11C;
  // input config field positions
  localparam int CFG_FREQ_LSB = 0;
  localparam int CFG_HF_LSB   = 4;
  localparam int CFG_DIRECT   = 6;
  localparam int CFG_LOCK8K   = 7;
  localparam int CFG_LINE_STD = 8;
  localparam logic [15:0] FRAC_RESET = 16'h0001;
  // slope selector codes and steps in ps per slope tick (1 ms)
  localparam logic [2:0] SLOPE_UNLIM = 3'h3;
  localparam logic [2:0] SLOPE_PROG  = 3'h7;
  localparam logic [2:0] SLOPE_RESET = 3'h7;
  localparam logic [31:0] STEP_61US  = 32'd61000;
  localparam logic [31:0] STEP_885NS = 32'd885;
  localparam logic [31:0] STEP_7U5   = 32'd7500;
  localparam logic [31:0] STEP_1NS   = 32'd1;
  localparam logic [31:0] STEP_5NS   = 32'd5;
  localparam logic [31:0] STEP_10NS  = 32'd10;
  // programmable full scale: 1484.3614 us/s in tenths of ps per ms
  localparam logic [31:0] PROG_FULL_SCALE_DPS = 32'd14843614;
  localparam int PROG_SCALE_SHIFT = 24;
  localparam logic [31:0] DPS_PER_PS = 32'd10;
  // secondary mode codes
  localparam logic [2:0] MODE_AUTO = 3'h0;
  localparam logic [2:0] MODE_FREE = 3'h1;
  localparam logic [2:0] MODE_HOLD = 3'h2;
  localparam logic [2:0] MODE_LOCK = 3'h4;
  // high-frequency divider codes and terminal counts
  localparam logic [1:0] HF_DIV4     = 2'h1;
  localparam logic [1:0] HF_DIV5     = 2'h2;
  localparam logic [2:0] HF_DIV4_END = 3'h3;
  localparam logic [2:0] HF_DIV5_END = 3'h4;
  // timing
  localparam int CLK_MHZ       = 250;
  localparam int CLK_PERIOD_PS = 1000000 / CLK_MHZ;
  localparam int SLOPE_TICK_US = 1000;
  localparam int SLOPE_TICK_CYCLES = SLOPE_TICK_US * CLK_MHZ;
  // 1.5 mHz averaging at one update per ms: alpha about 2^-17
  localparam int HOLD_AVG_SHIFT = 17;
  localparam int AVG_FRAC = 16;
  localparam logic [31:0] FLIMIT_RESET = 32'h7FFF_FFFF;

  typedef enum logic [1:0] {
    SEC_FREE = 2'b00,
    SEC_LOCK = 2'b01,
    SEC_HOLD = 2'b10
  } dpmp_sec_e;

  typedef struct packed {
    logic [15:0] num;
    logic [15:0] den;
    logic [14:0] integer_divider;
    logic [7:0]  integer_divider_lo;
    logic        line_std;
    logic        lock8k;
    logic        direct;
    logic [1:0]  hf;
    logic [3:0]  freq;
  } dpmp_incfg_s;

  typedef struct packed {
    logic [2:0]         sel_ref;
    logic               in_holdover;
    logic               in_freerun;
    logic               out_tick;
    logic signed [31:0] phase_req;
    logic signed [31:0] freq_req;
  } dpmp_prim_in_s;

  typedef struct packed {
    logic               ref_selected;
    logic               disqualified;
    logic               higher_prio;
    logic               forced_switch;
    logic signed [31:0] integral_freq;
  } dpmp_sec_in_s;

  typedef struct packed {
    logic [11:0]                   ctrl;
    logic [23:0]                   slope_val;
    logic [31:0]                   flimit;
    dpmp_incfg_s [NUM_IN-1:0]      incfg;
    logic [NUM_IN-1:0]             sync1;
    logic [NUM_IN-1:0]             sync2;
    logic [NUM_IN-1:0]             prev;
    logic [NUM_IN-1:0][2:0]        hf_cnt;
    logic [NUM_IN-1:0][14:0]       dn_cnt;
    logic [NUM_IN-1:0][16:0]       fr_acc;
    logic [NUM_IN-1:0]             div_tick;
    logic [31:0]                   time_cnt;
    logic [31:0]                   ref_time;
    logic [31:0]                   out_time;
    logic signed [31:0]            comp;
    logic [2:0]                    last_sel;
    logic                          last_hf;
    logic                          hs_event;
    logic [31:0]                   tick_cnt;
    logic                          ms_tick;
    logic signed [31:0]            phase_out;
    dpmp_sec_e                     sec_state;
    logic signed [31:0]            sec_inst;
    logic signed [47:0]            sec_avg;
    logic signed [31:0]            sec_hold;
    logic signed [31:0]            sec_freq;
    logic signed [31:0]            prim_freq;
    logic [31:0]                   rdata;
  } dpmp_state_s;

  // required loop input rate in Hz for a frequency code
  function automatic logic [31:0] freq_hz(input logic [3:0] code, input logic line_std);
    case (code)
      4'h0:    freq_hz = 32'd8000;
      4'h1:    freq_hz = line_std ? 32'd1544000 : 32'd2048000;
      4'h2:    freq_hz = 32'd6480000;
      4'h9:    freq_hz = 32'd2000;
      4'hA:    freq_hz = 32'd4000;
      4'hB:    freq_hz = 32'd1;
      4'hC:    freq_hz = 32'd6250000;
      default: freq_hz = 32'h0000_0000;
    endcase
  endfunction
endpackage

//--- logic/dpmp_core.sv
// loop mode control, hitless switching, slope and frequency limiting, input pre-dividers
// assumes reference pins asynchronous below sys_clk/2; loop signals share sys_clk
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module dpmp_core #(
  parameter int SLOPE_TICK_CYCLES = dpmp_pkg::SLOPE_TICK_CYCLES
) (
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [31:0]                   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic [31:0]                        reg_rdata,
  input  wire logic [dpmp_pkg::NUM_IN-1:0]   ref_in,
  input  wire dpmp_pkg::dpmp_prim_in_s       primary,
  input  wire dpmp_pkg::dpmp_sec_in_s        secondary,
  output logic [dpmp_pkg::NUM_IN-1:0]        div_tick,
  output logic                               hitless_event,
  output logic signed [31:0]                 primary_phase_comp,
  output logic signed [31:0]                 primary_phase_out,
  output logic signed [31:0]                 primary_freq_out,
  output logic signed [31:0]                 secondary_freq_out,
  output logic [1:0]                         secondary_state,
  output logic                               secondary_enabled
);

  dpmp_pkg::dpmp_state_s s;
  dpmp_pkg::dpmp_state_s n;

  function automatic logic [7:0] in_addr(input int idx, input logic [7:0] sub);
    in_addr = dpmp_pkg::OFS_IN_BASE + 8'(idx * int'(dpmp_pkg::IN_STRIDE)) + sub;
  endfunction

  // hard frequency clamp, symmetric about zero
  function automatic logic signed [31:0] fclamp(input logic signed [31:0] x, input logic [31:0] lim);
    logic signed [31:0] l;
    l = $signed({1'b0, lim[30:0]});
    if (x > l)
      fclamp = l;
    else if (x < -l)
      fclamp = -l;
    else
      fclamp = x;
  endfunction

  function automatic logic [31:0] slope_step(input logic [2:0] sel, input logic [23:0] val);
    logic [55:0] p;
    p = 56'(val) * 56'(dpmp_pkg::PROG_FULL_SCALE_DPS);
    case (sel)
      3'h0:    slope_step = dpmp_pkg::STEP_61US;
      3'h1:    slope_step = dpmp_pkg::STEP_885NS;
      3'h2:    slope_step = dpmp_pkg::STEP_7U5;
      3'h4:    slope_step = dpmp_pkg::STEP_1NS;
      3'h5:    slope_step = dpmp_pkg::STEP_5NS;
      3'h6:    slope_step = dpmp_pkg::STEP_10NS;
      3'h7:    slope_step = 32'(p >> dpmp_pkg::PROG_SCALE_SHIFT) / dpmp_pkg::DPS_PER_PS;
      default: slope_step = 32'h0000_0000;
    endcase
  endfunction

  logic               edge_seen;
  logic               t1;
  logic               t2;
  logic               t3;
  logic [16:0]        facc;
  logic [2:0]         hf_end;
  logic               trig;
  logic               hold_free;
  logic signed [31:0] target;
  logic signed [31:0] diff;
  logic signed [31:0] step;
  logic [2:0]         slope_sel;
  logic [2:0]         mode_sel;
  logic signed [47:0] avg_in;

  always_comb begin
    n         = s;
    edge_seen = 1'b0;
    t1        = 1'b0;
    t2        = 1'b0;
    t3        = 1'b0;
    facc      = '0;
    hf_end    = '0;
    trig      = 1'b0;
    hold_free = primary.in_holdover | primary.in_freerun;
    target    = '0;
    diff      = '0;
    step      = '0;
    slope_sel = s.ctrl[dpmp_pkg::CTRL_SLOPE_LSB +: 3];
    mode_sel  = s.ctrl[dpmp_pkg::CTRL_MODE_LSB +: 3];
    avg_in    = '0;
    n.hs_event = 1'b0;
    n.ms_tick  = 1'b0;
    n.rdata    = '0;
    n.div_tick = '0;

    // pin synchronisers: second stage alone feeds logic
    n.sync1 = ref_in;
    n.sync2 = s.sync1;
    n.prev  = s.sync2;

    if (reg_wr) begin
      case (reg_addr)
        dpmp_pkg::OFS_CTRL:   n.ctrl = reg_wdata[11:0];
        dpmp_pkg::OFS_SLOPE:  n.slope_val = reg_wdata[23:0];
        dpmp_pkg::OFS_FLIMIT: n.flimit = reg_wdata;
        default: ;
      endcase
      for (int i = 0; i < dpmp_pkg::NUM_IN; i++) begin
        if (reg_addr == in_addr(i, dpmp_pkg::IN_CFG)) begin
          n.incfg[i].freq     = reg_wdata[dpmp_pkg::CFG_FREQ_LSB +: 4];
          n.incfg[i].hf       = (i < dpmp_pkg::NUM_HF_IN) ? reg_wdata[dpmp_pkg::CFG_HF_LSB +: 2] : 2'h0;
          n.incfg[i].direct   = reg_wdata[dpmp_pkg::CFG_DIRECT];
          n.incfg[i].lock8k   = reg_wdata[dpmp_pkg::CFG_LOCK8K];
          n.incfg[i].line_std = reg_wdata[dpmp_pkg::CFG_LINE_STD];
        end
        // low byte staged, committed by upper write
        if (reg_addr == in_addr(i, dpmp_pkg::IN_INTEGER_DIVIDER_LO))
          n.incfg[i].integer_divider_lo = reg_wdata[7:0];
        if (reg_addr == in_addr(i, dpmp_pkg::IN_INTEGER_DIVIDER_HI)) begin
          n.incfg[i].integer_divider = {reg_wdata[14:8], s.incfg[i].integer_divider_lo};
          n.dn_cnt[i]     = '0;
        end
        if (reg_addr == in_addr(i, dpmp_pkg::IN_FRAC)) begin
          n.incfg[i].num = reg_wdata[15:0];
          n.incfg[i].den = reg_wdata[31:16];
          n.fr_acc[i]    = '0;
        end
      end
    end

    if (reg_rd) begin
      case (reg_addr)
        dpmp_pkg::OFS_CTRL:   n.rdata = {20'h0_0000, s.ctrl};
        dpmp_pkg::OFS_SLOPE:  n.rdata = {8'h00, s.slope_val};
        dpmp_pkg::OFS_FLIMIT: n.rdata = s.flimit;
        dpmp_pkg::OFS_STATUS: n.rdata = {28'h000_0000, s.ctrl[dpmp_pkg::CTRL_FREEZE],
                                         ~s.ctrl[dpmp_pkg::CTRL_PDN], s.sec_state};
        dpmp_pkg::OFS_PHASE:  n.rdata = s.comp;
        default: ;
      endcase
      for (int i = 0; i < dpmp_pkg::NUM_IN; i++) begin
        if (reg_addr == in_addr(i, dpmp_pkg::IN_CFG))
          n.rdata = {23'h00_0000, s.incfg[i].line_std, s.incfg[i].lock8k, s.incfg[i].direct,
                     s.incfg[i].hf, s.incfg[i].freq};
        if (reg_addr == in_addr(i, dpmp_pkg::IN_INTEGER_DIVIDER_LO))
          n.rdata = {17'h0_0000, s.incfg[i].integer_divider};
        // required loop rate decoded per input
        if (reg_addr == in_addr(i, dpmp_pkg::IN_INTEGER_DIVIDER_HI))
          n.rdata = dpmp_pkg::freq_hz(s.incfg[i].freq, s.incfg[i].line_std);
        if (reg_addr == in_addr(i, dpmp_pkg::IN_FRAC))
          n.rdata = {s.incfg[i].den, s.incfg[i].num};
      end
    end

    // pre-divider chain per input
    for (int i = 0; i < dpmp_pkg::NUM_IN; i++) begin
      edge_seen = s.sync2[i] & ~s.prev[i];
      // divide by 4 or 5, else bypass
      hf_end = (s.incfg[i].hf == dpmp_pkg::HF_DIV5) ? dpmp_pkg::HF_DIV5_END : dpmp_pkg::HF_DIV4_END;
      if (s.incfg[i].hf == dpmp_pkg::HF_DIV4 || s.incfg[i].hf == dpmp_pkg::HF_DIV5) begin
        t1 = 1'b0;
        if (edge_seen) begin
          if (s.hf_cnt[i] >= hf_end) begin
            n.hf_cnt[i] = '0;
            t1 = 1'b1;
          end else
            n.hf_cnt[i] = s.hf_cnt[i] + 3'h1;
        end
      end else
        t1 = edge_seen;
      // factor + 1 edges per output pulse; bypass when both select bits clear
      t2 = t1;
      if (s.incfg[i].direct | s.incfg[i].lock8k) begin
        t2 = 1'b0;
        if (t1) begin
          if (n.dn_cnt[i] >= s.incfg[i].integer_divider) begin
            n.dn_cnt[i] = '0;
            t2 = 1'b1;
          end else
            n.dn_cnt[i] = n.dn_cnt[i] + 15'h0001;
        end
      end
      // rate scaled by den/num, i.e. divide by num/den
      t3 = t2;
      if (s.incfg[i].num != 16'h0000) begin
        t3 = 1'b0;
        if (t2) begin
          facc = n.fr_acc[i] + 17'(s.incfg[i].den);
          if (facc >= 17'(s.incfg[i].num)) begin
            facc = facc - 17'(s.incfg[i].num);
            t3 = 1'b1;
          end
          n.fr_acc[i] = facc;
        end
      end
      n.div_tick[i] = t3;
    end

    n.time_cnt = s.time_cnt + 32'h0000_0001;
    if (primary.sel_ref < 3'(dpmp_pkg::NUM_IN) && s.div_tick[primary.sel_ref])
      n.ref_time = s.time_cnt;
    if (primary.out_tick)
      n.out_time = s.time_cnt;

    n.last_sel = primary.sel_ref;
    n.last_hf  = hold_free;
    trig = s.last_sel != primary.sel_ref;
    trig = trig | (s.last_hf & ~hold_free);
    if (!s.ctrl[dpmp_pkg::CTRL_HS_EN])
      n.comp = '0;
    else if (trig && !s.ctrl[dpmp_pkg::CTRL_FREEZE]) begin
      n.hs_event = 1'b1;
      // inject measured offset, cancelling the step
      n.comp = 32'($signed(s.ref_time - s.out_time) * dpmp_pkg::CLK_PERIOD_PS);
    end

    if (s.tick_cnt >= 32'(SLOPE_TICK_CYCLES - 1)) begin
      n.tick_cnt = '0;
      n.ms_tick  = 1'b1;
    end else
      n.tick_cnt = s.tick_cnt + 32'h0000_0001;

    // slope limited tracking of compensated phase
    target = primary.phase_req - s.comp;
    diff   = target - s.phase_out;
    step   = $signed(slope_step(slope_sel, s.slope_val));
    if (slope_sel == dpmp_pkg::SLOPE_UNLIM)
      n.phase_out = target;
    else if (s.ms_tick) begin
      if (diff > step)
        n.phase_out = s.phase_out + step;
      else if (diff < -step)
        n.phase_out = s.phase_out - step;
      else
        n.phase_out = target;
    end

    n.prim_freq = fclamp(primary.freq_req, s.flimit);

    // secondary loop mode control
    if (s.ctrl[dpmp_pkg::CTRL_PDN])
      // held in free-run while powered down
      n.sec_state = dpmp_pkg::SEC_FREE;
    else begin
      case (mode_sel)
        dpmp_pkg::MODE_FREE: n.sec_state = dpmp_pkg::SEC_FREE;
        dpmp_pkg::MODE_HOLD: n.sec_state = dpmp_pkg::SEC_HOLD;
        dpmp_pkg::MODE_LOCK: n.sec_state = dpmp_pkg::SEC_LOCK;
        dpmp_pkg::MODE_AUTO: begin
          case (s.sec_state)
            dpmp_pkg::SEC_FREE: begin
              if (secondary.ref_selected)
                n.sec_state = dpmp_pkg::SEC_LOCK;
            end
            dpmp_pkg::SEC_LOCK: begin
              if (secondary.disqualified | secondary.higher_prio | secondary.forced_switch |
                  ~secondary.ref_selected)
                n.sec_state = dpmp_pkg::SEC_HOLD;
            end
            dpmp_pkg::SEC_HOLD: begin
              if (secondary.ref_selected)
                n.sec_state = dpmp_pkg::SEC_LOCK;
              else
                n.sec_state = dpmp_pkg::SEC_FREE;
            end
            default: n.sec_state = dpmp_pkg::SEC_FREE;
          endcase
        end
        default: n.sec_state = s.sec_state;
      endcase
    end

    // integral tracking and averaging while locked
    if (s.sec_state == dpmp_pkg::SEC_LOCK) begin
      n.sec_inst = secondary.integral_freq;
      avg_in = 48'(secondary.integral_freq) <<< dpmp_pkg::AVG_FRAC;
      if (s.ms_tick)
        n.sec_avg = s.sec_avg + ((avg_in - s.sec_avg) >>> dpmp_pkg::HOLD_AVG_SHIFT);
      if (n.sec_state == dpmp_pkg::SEC_HOLD) begin
        if (s.ctrl[dpmp_pkg::CTRL_AVG])
          n.sec_hold = 32'(s.sec_avg >>> dpmp_pkg::AVG_FRAC);
        else
          n.sec_hold = s.sec_inst;
      end
    end

    // locked tracks input, free-run adds no offset
    case (s.sec_state)
      dpmp_pkg::SEC_LOCK: n.sec_freq = fclamp(secondary.integral_freq, s.flimit);
      dpmp_pkg::SEC_HOLD: n.sec_freq = fclamp(s.sec_hold, s.flimit);
      default:            n.sec_freq = '0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s           <= '0;
      s.ctrl      <= dpmp_pkg::CTRL_RESET;
      s.flimit    <= dpmp_pkg::FLIMIT_RESET;
      s.sec_state <= dpmp_pkg::SEC_FREE;
      for (int i = 0; i < dpmp_pkg::NUM_IN; i++) begin
        s.incfg[i].num <= dpmp_pkg::FRAC_RESET;
        s.incfg[i].den <= dpmp_pkg::FRAC_RESET;
      end
    end else
      s <= n;
  end

  // enable flag kept in its own flop so the output has no gate after it
  logic en_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      en_q <= 1'b0;
    else
      en_q <= ~n.ctrl[dpmp_pkg::CTRL_PDN];
  end

  assign reg_rdata          = s.rdata;
  assign div_tick           = s.div_tick;
  assign hitless_event      = s.hs_event;
  assign primary_phase_comp = s.comp;
  assign primary_phase_out  = s.phase_out;
  assign primary_freq_out   = s.prim_freq;
  assign secondary_freq_out = s.sec_freq;
  assign secondary_state    = s.sec_state;
  assign secondary_enabled  = en_q;

endmodule
`default_nettype wire

//--- testbench/dpmp_core_sva.sv
// port-level assertions for the loop mode and pre-divider core
// assumes control writes land at the edge that strobes them
`timescale 1ns/10ps
`default_nettype none
module dpmp_core_sva (
  input wire logic                    sys_clk,
  input wire logic                    sys_rst,
  input wire logic [7:0]              reg_addr,
  input wire logic [31:0]             reg_wdata,
  input wire logic                    reg_wr,
  input wire dpmp_pkg::dpmp_prim_in_s primary,
  input wire dpmp_pkg::dpmp_sec_in_s  secondary,
  input wire logic                    hitless_event,
  input wire logic signed [31:0]      primary_phase_comp,
  input wire logic [1:0]              secondary_state,
  input wire logic                    secondary_enabled
);
  logic [11:0] ctrl;
  logic        live;
  logic        auto;
  assign live = ctrl[0] && !ctrl[1];
  assign auto = !ctrl[8] && ctrl[7:5] == dpmp_pkg::MODE_AUTO;
  // shadow of control, so armed and mode are known here
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      ctrl <= dpmp_pkg::CTRL_RESET;
    else if (reg_wr && reg_addr == dpmp_pkg::OFS_CTRL)
      ctrl <= reg_wdata[11:0];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_ref_moved;
    live && primary.sel_ref != $past(primary.sel_ref);
  endsequence
  sequence s_loop_resumed;
    live && $fell(primary.in_holdover || primary.in_freerun);
  endsequence
  a_hs_on_switch: assert property (s_ref_moved |=> hitless_event)
    else $error("no hitless event after reference change");
  a_hs_on_resume: assert property (s_loop_resumed |=> hitless_event)
    else $error("no hitless event after leaving holdover");
  a_hs_frozen_hold: assert property (ctrl[1] |=> !hitless_event && $stable(primary_phase_comp))
    else $error("hitless logic moved while frozen");
  a_hs_needs_arm: assert property (hitless_event |-> $past(live))
    else $error("hitless event while disarmed");
  a_power_up: assert property ($fell(ctrl[8]) |-> ##[0:1] secondary_enabled)
    else $error("secondary loop not enabled");
  a_forced_lock: assert property (!ctrl[8] && ctrl[7:5] == dpmp_pkg::MODE_LOCK |-> ##[1:2] secondary_state == 2'b01)
    else $error("forced lock not taken");
  a_auto_lock: assert property (auto && secondary_state == 2'b00 && secondary.ref_selected
    |-> ##[1:2] secondary_state == 2'b01)
    else $error("auto mode did not lock");
  a_auto_hold: assert property (auto && secondary_state == 2'b01 && (secondary.disqualified || secondary.forced_switch)
    |-> ##1 secondary_state == 2'b10)
    else $error("auto mode did not enter holdover");
endmodule
bind dpmp_core dpmp_core_sva u_dpmp_core_sva (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .primary(primary), .secondary(secondary),
  .hitless_event(hitless_event), .primary_phase_comp(primary_phase_comp), .secondary_state(secondary_state),
  .secondary_enabled(secondary_enabled));
`default_nettype wire

//--- testbench/dpmp_ref_src.sv
// reference and sync pin source: bursts of rising edges
// assumes start is a short pulse; pins rest low between bursts
`timescale 1ns/10ps
`default_nettype none
module dpmp_ref_src #(
  parameter logic [5:0] PINS  = 6'h01,
  parameter int         EDGES = 8
) (
  input  wire logic       start,
  output logic      [5:0] ref_in
);
  initial ref_in = 6'h00;
  // edge trains well below half the system clock rate
  always @(posedge start) begin
    repeat (EDGES) begin
      #7 ref_in = PINS;
      #13 ref_in = 6'h00;
    end
  end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench for the loop mode and pre-divider core
// assumes a 4 ns clock and a shortened slope tick
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic                    sys_clk;
  logic                    sys_rst;
  logic [7:0]              reg_addr;
  logic [31:0]             reg_wdata;
  logic                    reg_wr;
  logic                    reg_rd;
  logic [31:0]             reg_rdata;
  logic [5:0]              ref_in;
  logic [5:0]              div_tick;
  dpmp_pkg::dpmp_prim_in_s primary;
  dpmp_pkg::dpmp_sec_in_s  secondary;
  logic                    hitless_event;
  logic signed [31:0]      primary_freq_out;
  logic signed [31:0]      secondary_freq_out;
  logic [1:0]              secondary_state;
  logic signed [31:0]      phase_comp;
  logic signed [31:0]      phase_out;
  logic                    sec_en;
  logic                    start;
  int                      num_errors;
  int                      check_count;
  int                      hs_cnt;
  int                      tick_cnt [6];
  logic [2:0]              mc [3] = '{dpmp_pkg::MODE_FREE, dpmp_pkg::MODE_LOCK, dpmp_pkg::MODE_HOLD};
  logic [31:0]             fx [3] = '{32'h0000_0000, 32'h0000_03E8, 32'h0000_03E8};
  int                      ex [4] = '{6, 6, 8, 24};
  dpmp_core #(.SLOPE_TICK_CYCLES(16)) u_dpmp_core (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_in(ref_in),
    .primary(primary), .secondary(secondary), .div_tick(div_tick), .hitless_event(hitless_event),
    .primary_phase_comp(phase_comp), .primary_phase_out(phase_out), .primary_freq_out(primary_freq_out),
    .secondary_freq_out(secondary_freq_out), .secondary_state(secondary_state), .secondary_enabled(sec_en));
  dpmp_ref_src #(.PINS(6'h0F), .EDGES(24)) u_dpmp_ref_src (.start(start), .ref_in(ref_in));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (hitless_event === 1'b1)
      hs_cnt <= hs_cnt + 1;
    for (int i = 0; i < 6; i++)
      if (div_tick[i] === 1'b1)
        tick_cnt[i] <= tick_cnt[i] + 1;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(n, e, reg_rdata);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic results;
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    results();
  end
  initial begin
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    primary = '0;
    secondary = '0;
    start = 1'b0;
    num_errors = 0;
    check_count = 0;
    hs_cnt = 0;
    tick_cnt = '{default: 0};
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd_chk("ctrl reset", dpmp_pkg::OFS_CTRL, 32'h0000_011C);
    rd_chk("status reset", dpmp_pkg::OFS_STATUS, 32'h0000_0000);
    rd_chk("unmapped", 8'hFC, 32'h0000_0000);
    wr(dpmp_pkg::OFS_CTRL, 32'h0000_001C);
    secondary.ref_selected <= 1'b1;
    secondary.integral_freq <= 32'sh0000_03E8;
    tick(3);
    chk("auto state", 32'h0000_0001, 32'(secondary_state));
    chk("enabled", 32'h0000_0001, 32'(sec_en));
    for (int i = 0; i < 3; i++) begin
      wr(dpmp_pkg::OFS_CTRL, {24'h00_0000, mc[i], 5'h1C});
      if (i == 2)
        secondary.integral_freq <= 32'sh0000_0007;
      tick(3);
      chk("forced state", 32'(i), 32'(secondary_state));
      chk("secondary freq", fx[i], secondary_freq_out);
    end
    wr(dpmp_pkg::OFS_CTRL, 32'h0000_001C);
    tick(3);
    chk("relock", 32'h0000_0001, 32'(secondary_state));
    @(posedge sys_clk);
    secondary.ref_selected <= 1'b0;
    secondary.disqualified <= 1'b1;
    tick(4);
    chk("back to free", 32'h0000_0000, 32'(secondary_state));
    chk("free freq", 32'h0000_0000, secondary_freq_out);
    wr(dpmp_pkg::OFS_CTRL, 32'h0000_001D);
    primary.sel_ref <= 3'h1;
    tick(3);
    chk("switch event", 32'h0000_0001, hs_cnt);
    chk("comp", 32'h0000_0000, phase_comp);
    @(posedge sys_clk);
    primary.in_holdover <= 1'b1;
    @(posedge sys_clk);
    primary.in_holdover <= 1'b0;
    tick(3);
    chk("resume event", 32'h0000_0002, hs_cnt);
    wr(dpmp_pkg::OFS_CTRL, 32'h0000_001F);
    primary.sel_ref <= 3'h2;
    tick(3);
    chk("frozen", 32'h0000_0002, hs_cnt);
    wr(dpmp_pkg::OFS_FLIMIT, 32'h0000_0064);
    primary.freq_req <= 32'sh0000_01F4;
    tick(3);
    chk("clamp high", 32'h0000_0064, primary_freq_out);
    @(posedge sys_clk);
    primary.freq_req <= -32'sh0000_01F4;
    tick(3);
    chk("clamp low", 32'hFFFF_FF9C, primary_freq_out);
    wr(dpmp_pkg::OFS_CTRL, 32'h0000_000C);
    primary.phase_req <= 32'sh0000_0040;
    tick(3);
    chk("unlimited phase", 32'h0000_0040, phase_out);
    wr(dpmp_pkg::OFS_CTRL, 32'h0000_001C);
    primary.phase_req <= 32'sh0000_0140;
    tick(40);
    chk("zero slope", 32'h0000_0040, phase_out);
    wr(8'h20, 32'h0000_0010);
    wr(8'h30, 32'h0000_0040);
    wr(8'h34, 32'h0000_0003);
    wr(8'h38, 32'h0000_0000);
    wr(8'h4C, 32'h0001_0003);
    rd_chk("factor", 8'h34, 32'h0000_0003);
    @(posedge sys_clk);
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    tick(140);
    for (int i = 0; i < 4; i++)
      chk("divider ticks", ex[i], tick_cnt[i]);
    results();
  end
endmodule
`default_nettype wire
